/* core_sfr.sv */
// special-function register set of the controller core
// assumes one clock; the instruction logic drives byte, bit and update ports
// Notes on behaviour
// [RULE1] registers live in upper 128 bytes, reached by direct address only
// [RULE2] all core registers here except program counter, instruction register, banks
// [RULE3] two bank-select bits choose register bank 0 to 3 as binary number
// [RULE4] carry updated by add, add-with-carry, subtract, multiply and divide
// [RULE5] half carry updated only by add and add-with-carry
// [RULE6] signed excess updated by add, add-with-carry, subtract, multiply, divide
// [RULE7] status bit 0 always gives even parity over the accumulator
// [RULE8] status bits 5 and 1 are user flags, never touched by results
// [RULE9] power control bit 7 doubles serial baud rate, resets to 0
// [RULE10] data pointer is high byte then low byte, both reset to zero
// [RULE11] stack address is 11 bits: low register plus upper bits 2 to 0
// [RULE12] upper bits 5 to 3 hold stack origin, reset 001; bit 6 floor flag
// [RULE13] violation gives interrupt when control bit 2 low, reset when high
// [RULE14] control bit 1 enables boundary checking, reset disabled
// [RULE15] control bits 7 to 3 hold fill level; bit 0 is fill flag
// [RULE16] software keeps reserved power control bits zero when writing
// [RULE17] push increments then writes; pop reads then decrements
// [RULE18] four eight-byte banks sit in the lowest 32 RAM bytes
// [RULE19] guarded stack below origin sets floor flag and violation action
// [RULE20] stack reaching fill level sets sticky fill flag until cleared
`include "core_sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module core_sfr (
   input wire logic clk,
   input wire logic rstn,
   // byte access
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   // bit access
   input wire logic [7:0] bit_addr,
   input wire logic bit_wr,
   input wire logic bit_rd,
   input wire logic bit_wdata,
   output logic bit_rdata,
   // instruction results
   input wire logic acc_load,
   input wire logic [7:0] acc_value,
   input wire logic math_load,
   input wire logic [7:0] math_value,
   input wire core_sfr_pkg::alu_op_e alu_op,
   input wire logic carry_in,
   input wire logic half_carry_in,
   input wire logic excess_in,
   input wire logic pointer_load,
   input wire logic [15:0] pointer_value,
   input wire logic stack_push,
   input wire logic stack_pop,
   // state towards the core
   output logic [7:0] accumulator,
   output logic [7:0] math_operand,
   output logic carry_flag,
   output logic parity_flag,
   output logic [4:0] bank_base,
   output logic baud_doubler,
   output logic [15:0] data_pointer_value,
   output core_sfr_pkg::stack_addr_t stack_addr,
   output logic [7:0] core_configuration,
   output logic stack_irq,
   output logic stack_reset_req
);

   logic [7:0] acc_q, acc_d;
   logic [7:0] math_q, math_d;
   logic [7:0] status_q, status_d;
   logic pwr_q, pwr_d;
   logic [7:0] ptr_lo_q, ptr_lo_d;
   logic [7:0] ptr_hi_q, ptr_hi_d;
   logic [7:0] conf_q, conf_d;
   logic [10:0] stk_q, stk_d;
   logic [2:0] origin_q, origin_d;
   logic floor_q, floor_d;
   logic [4:0] level_q, level_d;
   logic rst_sel_q, rst_sel_d;
   logic guard_q, guard_d;
   logic fill_q, fill_d;
   logic [7:0] rdata_q;
   logic hit_q;
   logic bitr_q;
   logic irq_q, rstreq_q;

   // direct space only: bit 7 of the address must be set
   function automatic logic [7:0] read_byte(input logic [7:0] a); // [RULE1]
      logic [7:0] r;
      r = `RST_BYTE;
      unique case (a)
         `ADDR_STK_LOW: r = stk_q[7:0];
         `ADDR_PTR_LOW: r = ptr_lo_q;
         `ADDR_PTR_HIGH: r = ptr_hi_q;
         `ADDR_POWER: r = {pwr_q, 7'h00};
         `ADDR_CONFIG: r = conf_q;
         `ADDR_STK_UPPER: r = {1'b1, floor_q, origin_q, stk_q[10:8]};
         `ADDR_STACK_CTL: r = {level_q, rst_sel_q, guard_q, fill_q};
         `ADDR_STATUS: r = {status_q[7:1], ^acc_q}; // [RULE7]
         `ADDR_WORK: r = acc_q;
         `ADDR_MATH: r = math_q;
         default: r = `RST_BYTE;
      endcase
      return r;
   endfunction : read_byte

   function automatic logic mapped(input logic [7:0] a);
      logic m;
      m = 1'b0;
      unique case (a)
         `ADDR_STK_LOW, `ADDR_PTR_LOW, `ADDR_PTR_HIGH, `ADDR_POWER,
         `ADDR_CONFIG, `ADDR_STK_UPPER, `ADDR_STACK_CTL, `ADDR_STATUS,
         `ADDR_WORK, `ADDR_MATH: m = 1'b1;
         default: m = 1'b0;
      endcase
      return m;
   endfunction : mapped

   // bit space: 0x80 and up, only the status, work and math bytes at D0, E0 and F0
   wire [7:0] bit_byte = {bit_addr[7:3], 3'b000};
   wire bit_ok = bit_addr[`SFR_SPACE_BIT] && (bit_byte == `ADDR_STATUS ||
      bit_byte == `ADDR_WORK || bit_byte == `ADDR_MATH);
   // live status byte: the parity bit is never stored, always rebuilt
   wire [7:0] status_rd = {status_q[7:1], ^acc_q}; // [RULE7]
   // mux straight off the registers, so it follows every register change
   wire [7:0] bit_old = (bit_byte == `ADDR_STATUS) ? status_rd :
      (bit_byte == `ADDR_WORK) ? acc_q :
      (bit_byte == `ADDR_MATH) ? math_q : `RST_BYTE;
   wire [2:0] bit_pos = bit_addr[2:0];
   wire [7:0] bit_mask = 8'h01 << bit_pos;
   wire [7:0] bit_new = bit_wdata ? (bit_old | bit_mask) : (bit_old & ~bit_mask);

   // byte write wins over a bit write in the same cycle
   wire byte_wr = sfr_wr && sfr_addr[`SFR_SPACE_BIT]; // [RULE1]
   wire any_wr = byte_wr || (bit_wr && bit_ok);
   wire [7:0] wa = byte_wr ? sfr_addr : bit_byte;
   wire [7:0] wd = byte_wr ? sfr_wdata : bit_new;
   wire wr_stk_lo = any_wr && wa == `ADDR_STK_LOW;
   wire wr_ptr_lo = any_wr && wa == `ADDR_PTR_LOW;
   wire wr_ptr_hi = any_wr && wa == `ADDR_PTR_HIGH;
   wire wr_pwr = any_wr && wa == `ADDR_POWER;
   wire wr_conf = any_wr && wa == `ADDR_CONFIG;
   wire wr_stk_hi = any_wr && wa == `ADDR_STK_UPPER;
   wire wr_sc = any_wr && wa == `ADDR_STACK_CTL;
   wire wr_status = any_wr && wa == `ADDR_STATUS;
   wire wr_acc = any_wr && wa == `ADDR_WORK;
   wire wr_math = any_wr && wa == `ADDR_MATH;

   // arithmetic flag updates by instruction kind
   wire op_carry = alu_op inside {core_sfr_pkg::alu_add, core_sfr_pkg::alu_addc,
      core_sfr_pkg::alu_subb, core_sfr_pkg::alu_mul, core_sfr_pkg::alu_div}; // [RULE4] [RULE6]
   wire op_half = alu_op inside {core_sfr_pkg::alu_add, core_sfr_pkg::alu_addc}; // [RULE5]

   // stack address movement
   // a push or pop overrides a software write of the stack address
   wire [10:0] stk_written = {wr_stk_hi ? wd[`SPU_STK_HI:0] : stk_q[10:8],
      wr_stk_lo ? wd : stk_q[7:0]}; // [RULE11]
   wire [10:0] stk_next = stack_push ? stk_q + 11'h001 :
      stack_pop ? stk_q - 11'h001 : stk_written; // [RULE17]
   wire stk_moves = stack_push || stack_pop || wr_stk_lo || wr_stk_hi;
   wire [10:0] origin_addr = {origin_q, 8'h00};
   wire below = guard_q && stk_moves && (stk_next < origin_addr); // [RULE14] [RULE19]
   // level 0 switches the fill comparison off
   wire at_level = (level_q != 5'h00) && (stk_q[10:6] >= level_q); // [RULE20]

   always_comb begin
      acc_d = acc_q;
      if (wr_acc) begin
         acc_d = wd;
      end
      if (acc_load) begin
         acc_d = acc_value;
      end
   end

   always_comb begin
      math_d = math_q;
      if (wr_math) begin
         math_d = wd;
      end
      if (math_load) begin
         math_d = math_value;
      end
   end

   // user flags and bank bits only change by software writes
   always_comb begin
      status_d = status_q;
      if (wr_status) begin
         status_d = {wd[7:1], 1'b0}; // [RULE8]
      end
      if (op_carry) begin
         status_d[`ST_CARRY] = carry_in; // [RULE4]
         status_d[`ST_EXCESS] = excess_in; // [RULE6]
      end
      if (op_half) begin
         status_d[`ST_HALF] = half_carry_in; // [RULE5]
      end
   end

   // reserved power bits are dropped, software keeps them zero
   assign pwr_d = wr_pwr ? wd[`PWR_DOUBLER] : pwr_q; // [RULE9] [RULE16]
   assign ptr_lo_d = pointer_load ? pointer_value[7:0] : (wr_ptr_lo ? wd : ptr_lo_q); // [RULE10]
   assign ptr_hi_d = pointer_load ? pointer_value[15:8] : (wr_ptr_hi ? wd : ptr_hi_q); // [RULE10]
   assign conf_d = wr_conf ? wd : conf_q;
   assign stk_d = stk_next;
   assign origin_d = wr_stk_hi ? wd[`SPU_ORIGIN_HI:`SPU_ORIGIN_LO] : origin_q; // [RULE12]
   // software clears by writing 0; a new event wins over the clear
   assign floor_d = below || (wr_stk_hi ? (floor_q && wd[`SPU_FLOOR]) : floor_q); // [RULE19]
   assign level_d = wr_sc ? wd[`SC_LEVEL_HI:`SC_LEVEL_LO] : level_q; // [RULE15]
   assign rst_sel_d = wr_sc ? wd[`SC_RESET_SEL] : rst_sel_q;
   assign guard_d = wr_sc ? wd[`SC_GUARD_EN] : guard_q; // [RULE14]
   assign fill_d = at_level || (wr_sc ? (fill_q && wd[`SC_FILL_FLAG]) : fill_q); // [RULE20]

   // byte registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_q <= `RST_BYTE;
         math_q <= `RST_BYTE;
         status_q <= `RST_BYTE;
         pwr_q <= 1'b0; // [RULE9]
         {ptr_hi_q, ptr_lo_q} <= `RST_POINTER; // [RULE10]
         conf_q <= `RST_CONFIG;
      end else begin
         acc_q <= acc_d;
         math_q <= math_d;
         status_q <= status_d;
         pwr_q <= pwr_d;
         ptr_lo_q <= ptr_lo_d;
         ptr_hi_q <= ptr_hi_d;
         conf_q <= conf_d;
      end
   end

   // stack address, origin and guard state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stk_q <= `RST_STK; // [RULE11]
         origin_q <= `RST_ORIGIN; // [RULE12]
         floor_q <= 1'b0;
         level_q <= 5'h00;
         rst_sel_q <= 1'b0;
         guard_q <= 1'b0; // [RULE14]
         fill_q <= 1'b0;
      end else begin
         stk_q <= stk_d;
         origin_q <= origin_d;
         floor_q <= floor_d;
         level_q <= level_d;
         rst_sel_q <= rst_sel_d;
         guard_q <= guard_d;
         fill_q <= fill_d;
      end
   end

   // violation action, one-cycle pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_q <= 1'b0;
         rstreq_q <= 1'b0;
      end else begin
         irq_q <= below && !rst_sel_q; // [RULE13]
         rstreq_q <= below && rst_sel_q; // [RULE13]
      end
   end

   // read data registered one cycle after the strobe
   // a read beside a write in one cycle returns the old value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= `RST_BYTE;
         hit_q <= 1'b0;
         bitr_q <= 1'b0;
      end else begin
         if (sfr_rd) begin
            rdata_q <= read_byte(sfr_addr);
            hit_q <= mapped(sfr_addr);
         end
         if (bit_rd) begin
            bitr_q <= bit_ok && bit_old[bit_pos];
         end
      end
   end

   assign sfr_rdata = rdata_q;
   assign sfr_hit = hit_q;
   assign bit_rdata = bitr_q;
   assign accumulator = acc_q;
   assign math_operand = math_q;
   assign carry_flag = status_q[`ST_CARRY];
   assign parity_flag = ^acc_q; // [RULE7]
   // bank base address within lowest 32 bytes of RAM
   assign bank_base = {status_q[`ST_BANK_HI], status_q[`ST_BANK_LO], 3'b000}; // [RULE3] [RULE18]
   assign baud_doubler = pwr_q; // [RULE9]
   assign data_pointer_value = {ptr_hi_q, ptr_lo_q}; // [RULE10]
   assign stack_addr = stk_q; // [RULE2]
   assign core_configuration = conf_q;
   assign stack_irq = irq_q;
   assign stack_reset_req = rstreq_q;

endmodule : core_sfr

`default_nettype wire

/* core_sfr_assertions.sv */
// port-level checker for the core register file
// assumes binding onto core_sfr, ports matched by name
`timescale 1ns/1ps
`default_nettype none
module core_sfr_assertions (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sfr_wr,
   input wire logic bit_wr,
   input wire logic acc_load,
   input wire logic [7:0] acc_value,
   input wire core_sfr_pkg::alu_op_e alu_op,
   input wire logic carry_in,
   input wire logic pointer_load,
   input wire logic [15:0] pointer_value,
   input wire logic stack_push,
   input wire logic stack_pop,
   input wire logic [7:0] accumulator,
   input wire logic carry_flag,
   input wire logic parity_flag,
   input wire logic [4:0] bank_base,
   input wire logic [15:0] data_pointer_value,
   input wire core_sfr_pkg::stack_addr_t stack_addr,
   input wire logic stack_irq,
   input wire logic stack_reset_req
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_push;
      stack_push;
   endsequence
   sequence s_pop;
      stack_pop && !stack_push;
   endsequence
   a_parity_even: assert property (parity_flag == ^accumulator)
      else $error("parity flag wrong");
   a_bank_aligned: assert property (!sfr_wr && !bit_wr |=> $stable(bank_base) && bank_base[2:0] == 3'h0)
      else $error("bank base misaligned");
   a_push_step: assert property (s_push |=> stack_addr - $past(stack_addr) == 11'h001)
      else $error("push step wrong");
   a_pop_step: assert property (s_pop |=> stack_addr - $past(stack_addr) == 11'h7FF)
      else $error("pop step wrong");
   a_carry_load: assert property (alu_op != core_sfr_pkg::alu_none |=> carry_flag == $past(carry_in))
      else $error("carry not loaded");
   a_carry_hold: assert property (alu_op == core_sfr_pkg::alu_none && !sfr_wr && !bit_wr |=> $stable(carry_flag))
      else $error("carry changed");
   a_pointer_load: assert property (pointer_load |=> data_pointer_value == $past(pointer_value))
      else $error("pointer not loaded");
   a_acc_load: assert property (acc_load |=> accumulator == $past(acc_value))
      else $error("accumulator not loaded");
   a_irq_pulse: assert property (stack_irq |=> !stack_irq)
      else $error("irq too long");
   a_action_one: assert property (!(stack_irq && stack_reset_req))
      else $error("both actions");
endmodule : core_sfr_assertions
bind core_sfr core_sfr_assertions i_core_sfr_assertions (.*);
`default_nettype wire

/* core_sfr_cfg.svh */
// core special-register map: offsets, field positions, reset values
// assumes inclusion by bare name from the core register file
`ifndef CORE_SFR_CFG_SVH
`define CORE_SFR_CFG_SVH

// direct-address window (upper half of internal data space)
`define SFR_SPACE_BIT 7
// byte offsets
`define ADDR_STK_LOW 8'h81
`define ADDR_PTR_LOW 8'h82
`define ADDR_PTR_HIGH 8'h83
`define ADDR_POWER 8'h87
`define ADDR_CONFIG 8'hAF
`define ADDR_STK_UPPER 8'hB7
`define ADDR_STACK_CTL 8'hBF
`define ADDR_STATUS 8'hD0
`define ADDR_WORK 8'hE0
`define ADDR_MATH 8'hF0
// status word fields
`define ST_CARRY 7
`define ST_HALF 6
`define ST_USER0 5
`define ST_BANK_HI 4
`define ST_BANK_LO 3
`define ST_EXCESS 2
`define ST_USER1 1
`define ST_PARITY 0
// power control
`define PWR_DOUBLER 7
// upper stack register
`define SPU_FIXED 7
`define SPU_FLOOR 6
`define SPU_ORIGIN_HI 5
`define SPU_ORIGIN_LO 3
`define SPU_STK_HI 2
// stack control
`define SC_LEVEL_HI 7
`define SC_LEVEL_LO 3
`define SC_RESET_SEL 2
`define SC_GUARD_EN 1
`define SC_FILL_FLAG 0
// reset values
`define RST_BYTE 8'h00
`define RST_CONFIG 8'h81
`define RST_ORIGIN 3'h1
`define RST_STK 11'h100
`define RST_POINTER 16'h0000

`endif

/* core_sfr_pkg.sv */
// types shared by the core register file and its user
// assumes the instruction logic reports one arithmetic kind per cycle
package core_sfr_pkg;
   // arithmetic instruction kind retiring in this cycle
   typedef enum logic [2:0] {
      alu_none,
      alu_add,
      alu_addc,
      alu_subb,
      alu_mul,
      alu_div
   } alu_op_e;
   typedef logic [10:0] stack_addr_t;
endpackage : core_sfr_pkg

/* stack_ram_model.sv */
// stack byte store of the instruction logic
// assumes push pulses beside the register file
`timescale 1ns/1ps
`default_nettype none
module stack_ram_model (
   input wire logic clk,
   input wire logic stack_push,
   input wire core_sfr_pkg::stack_addr_t stack_addr,
   input wire logic [7:0] push_data,
   output logic [7:0] pop_data
);
   logic [7:0] mem_q [0:2047];
   logic pend_q;
   logic [7:0] data_q;
   // address moves first, byte lands at the new top
   always_ff @(posedge clk) begin
      pend_q <= stack_push;
      data_q <= push_data;
      if (pend_q) begin
         mem_q[stack_addr] <= data_q;
      end
   end
   // pop reads the top before it drops
   assign pop_data = mem_q[stack_addr];
endmodule : stack_ram_model
`default_nettype wire

/* test_core_sfr.sv */
// self-checking bench for the core register file
// assumes the checker binds itself and the stack model sits beside
`timescale 1ns/1ps
`default_nettype none
module test_core_sfr;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, acc_value = 8'h00, push_data = 8'h00;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0, bit_wdata = 1'b0, acc_load = 1'b0, pointer_load = 1'b0;
   logic carry_in = 1'b0, half_carry_in = 1'b0, excess_in = 1'b0, stack_push = 1'b0, stack_pop = 1'b0;
   logic bit_rd = 1'b0, math_load = 1'b0, bit_rdata;
   logic [7:0] math_value = 8'h00, math_operand, core_configuration;
   logic [15:0] pointer_value = 16'h0000;
   core_sfr_pkg::alu_op_e alu_op = core_sfr_pkg::alu_none;
   logic [7:0] sfr_rdata, accumulator, pop_data;
   logic sfr_hit, parity_flag, carry_flag, baud_doubler, stack_irq, stack_reset_req;
   logic [4:0] bank_base;
   logic [15:0] data_pointer_value, w;
   core_sfr_pkg::stack_addr_t stack_addr;
   int error_cnt = 0, compares = 0;
   always #5 clk = ~clk;
   core_sfr i_core_sfr (.*);
   stack_ram_model i_stack_ram_model (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      chk(sfr_rdata, exp, "read data");
      chk(sfr_hit, hit, "hit");
   endtask : rd
   task automatic bw(input logic [7:0] a, input logic v);
      @(posedge clk);
      bit_addr <= a;
      bit_wdata <= v;
      bit_wr <= 1'b1;
      @(posedge clk);
      bit_wr <= 1'b0;
      #1;
   endtask : bw
   task automatic br(input logic [7:0] a, input logic exp);
      @(posedge clk);
      bit_addr <= a;
      bit_rd <= 1'b1;
      @(posedge clk);
      bit_rd <= 1'b0;
      #1;
      chk(bit_rdata, exp, "bit read");
   endtask : br
   task automatic move(input logic up, input logic [7:0] d);
      @(posedge clk);
      push_data <= d;
      stack_push <= up;
      stack_pop <= !up;
      @(posedge clk);
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      #1;
   endtask : move
   function automatic logic [7:0] status_exp(input int op);
      logic cy;
      logic ac;
      cy = (op != 0);
      ac = (op == 1) || (op == 2);
      return {cy, ac, 1'b1, 2'b00, cy, 1'b1, 1'b0};
   endfunction : status_exp
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      w = 16'($urandom(32'hC0C2));
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rd(8'hB7, 8'h89, 1'b1);
      rd(8'hBF, 8'h00, 1'b1);
      rd(8'h87, 8'h00, 1'b1);
      rd(8'h83, 8'h00, 1'b1);
      rd(8'hAF, 8'h81, 1'b1);
      chk(core_configuration, 16'h0081, "configuration");
      wr(8'hAF, 8'h5A);
      chk(core_configuration, 16'h005A, "configuration");
      rd(8'h80, 8'h00, 1'b0);
      wr(8'h40, 8'hFF);
      rd(8'h40, 8'h00, 1'b0);
      chk(stack_addr, 16'h0100, "stack addr");
      for (int i = 0; i < 8; i++) begin
         w = 16'($urandom);
         if (i[0]) begin
            @(posedge clk);
            acc_value <= w[7:0];
            acc_load <= 1'b1;
            @(posedge clk);
            acc_load <= 1'b0;
            #1;
         end else begin
            wr(8'hE0, w[7:0]);
         end
         chk(accumulator, w[7:0], "accumulator");
         rd(8'hD0, {7'h00, ^w[7:0]}, 1'b1);
      end
      wr(8'hE0, 8'h00);
      for (int i = 0; i < 4; i++) begin
         bw(8'hD3, i[0]);
         bw(8'hD4, i[1]);
         chk(bank_base, 16'(i * 8), "bank base");
      end
      br(8'hD4, 1'b1);
      br(8'hD5, 1'b0);
      for (int i = 0; i < 6; i++) begin
         wr(8'hD0, 8'h22);
         @(posedge clk);
         alu_op <= core_sfr_pkg::alu_op_e'(i);
         {carry_in, half_carry_in, excess_in} <= 3'h7;
         @(posedge clk);
         alu_op <= core_sfr_pkg::alu_none;
         #1;
         rd(8'hD0, status_exp(i), 1'b1);
      end
      wr(8'h87, 8'h80);
      chk(baud_doubler, 16'h0001, "baud doubler");
      rd(8'h87, 8'h80, 1'b1);
      w = 16'($urandom);
      wr(8'h82, w[7:0]);
      wr(8'h83, w[15:8]);
      chk(data_pointer_value, w, "data pointer");
      w = 16'($urandom);
      @(posedge clk);
      pointer_value <= w;
      pointer_load <= 1'b1;
      @(posedge clk);
      pointer_load <= 1'b0;
      #1;
      rd(8'h83, w[15:8], 1'b1);
      w = 16'($urandom);
      wr(8'hF0, w[7:0]);
      chk(math_operand, w[7:0], "math operand");
      @(posedge clk);
      math_value <= w[15:8];
      math_load <= 1'b1;
      @(posedge clk);
      math_load <= 1'b0;
      #1;
      rd(8'hF0, w[15:8], 1'b1);
      move(1'b1, 8'hA5);
      move(1'b1, 8'h5A);
      @(posedge clk);
      #1;
      chk(pop_data, 16'h005A, "top byte");
      move(1'b0, 8'h00);
      chk(pop_data, 16'h00A5, "next byte");
      move(1'b0, 8'h00);
      wr(8'hBF, 8'h02);
      move(1'b0, 8'h00);
      chk({stack_irq, stack_reset_req}, 16'h0002, "violation");
      rd(8'hB7, 8'hC8, 1'b1);
      wr(8'hBF, 8'h06);
      move(1'b0, 8'h00);
      chk({stack_irq, stack_reset_req}, 16'h0001, "violation");
      wr(8'hBF, 8'h00);
      move(1'b1, 8'h00);
      move(1'b1, 8'h00);
      wr(8'hB7, 8'h09);
      rd(8'hB7, 8'h89, 1'b1);
      wr(8'hBF, 8'h28);
      rd(8'hBF, 8'h28, 1'b1);
      wr(8'hBF, 8'h20);
      rd(8'hBF, 8'h21, 1'b1);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(8'hBF, 8'h00, 1'b1);
      chk(baud_doubler, 16'h0000, "baud doubler");
      chk(data_pointer_value, 16'h0000, "data pointer");
      chk(stack_addr, 16'h0100, "stack addr");
      print_verdict();
   end
endmodule : test_core_sfr
`default_nettype wire
